// File: hw/uvh_consts.svh
/*
  Timing and layout constants for the EPROM programming and read controller.
  Assumes a 10 MHz controller clock. Every delay is given in its own unit and
  converted to whole clock cycles here.
*/
`ifndef UVH_CONSTS_SVH
`define UVH_CONSTS_SVH

`define UVH_CLK_NS        100
// Settling time for address, data and supply changes.
`define UVH_SETTLE_NS     200
// Program pulse length on the chip select, in microseconds.
`define UVH_PULSE_US      100
// Verify valid delay after chip select falls.
`define UVH_VERIFY_NS     150
// Address access delay of the slowest speed grade.
`define UVH_ACCESS_NS     150
// Extra cycles for the three-stage data input synchroniser.
`define UVH_SYNC_LAT      4
`define UVH_SETTLE_CYC    ((`UVH_SETTLE_NS + `UVH_CLK_NS - 1) / `UVH_CLK_NS)
`define UVH_PULSE_CYC     ((`UVH_PULSE_US * 1000 + `UVH_CLK_NS - 1) / `UVH_CLK_NS)
`define UVH_VER_CYC       (((`UVH_VERIFY_NS + `UVH_CLK_NS - 1) / `UVH_CLK_NS) + `UVH_SYNC_LAT)
`define UVH_ACC_CYC       (((`UVH_ACCESS_NS + `UVH_CLK_NS - 1) / `UVH_CLK_NS) + `UVH_SYNC_LAT)
`define UVH_MAX_PULSES    5'h19
`define UVH_LAST_ADDR     16'hffff
`define UVH_FIRST_ADDR    16'h0000

`endif

// File: hw/uvh_pkg.sv
/*
  Types for the EPROM programming and read controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uvh_pkg;

  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_IDENT   = 2'h1,
    OP_PROGRAM = 2'h2
  } uvh_op_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_PWR   = 4'h1,
    ST_SETUP = 4'h3,
    ST_PULSE = 4'h2,
    ST_GAP   = 4'h6,
    ST_VER   = 4'h7,
    ST_FPWR  = 4'h5,
    ST_FREAD = 4'h4,
    ST_READ  = 4'hc,
    ST_DONE  = 4'hd
  } uvh_state_t;

  typedef struct packed {
    uvh_op_t     op;
    logic [15:0] addr;
  } uvh_req_t;

  typedef struct packed {
    logic [7:0]  rdata;
    logic        pass;
    logic [15:0] fail_addr;
  } uvh_resp_t;

  // Pin drive toward the memory; the three qualifiers vpp_en, vcc_prog and
  // identify_high_level stand for levels above the normal logic swing.
  typedef struct packed {
    logic [15:0] word_address;
    logic        ce_n;
    logic        oe_n;
    logic        vpp_en;
    logic        vcc_prog;
    logic        identify_high_level;
    logic [7:0]  byte_data_out;
    logic        byte_data_oe;
  } uvh_pins_t;

endpackage

// File: hw/uvh_pin_sync.sv
/*
  Three-stage synchroniser for the memory data lines.
  Assumes the lines change without regard to clk; the output updates only
  once the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module uvh_pin_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] d,
  output var  logic [7:0] q
);

  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  logic [7:0] next_q;

  // Only bits whose two late stages agree are taken, so a bit caught
  // mid-transition never reaches the comparator.
  always_comb begin
    next_q = q;
    for (int i = 0; i < 8; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 8'hff;
      s2 <= 8'hff;
      s3 <= 8'hff;
      q  <= 8'hff;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

endmodule // uvh_pin_sync

`default_nettype wire

// File: hw/uvh_ctrl.sv
/*
  Controller that reads, identifies and programs a 64K by 8 UV EPROM
  through its pins. Assumes the supply and high-voltage switches follow
  vcc_prog, vpp_en and identify_high_level, and that image_data is a
  function of image_addr from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uvh_consts.svh"

module uvh_ctrl (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire uvh_pkg::uvh_req_t req,
  output logic                   resp_valid,
  output uvh_pkg::uvh_resp_t     resp,
  output logic [15:0]            image_addr,
  input  wire logic [7:0]        image_data,
  output uvh_pkg::uvh_pins_t     pins,
  input  wire logic [7:0]        byte_data_lines
);

  uvh_pkg::uvh_state_t state;
  uvh_pkg::uvh_state_t next_state;
  uvh_pkg::uvh_op_t    op;
  uvh_pkg::uvh_op_t    next_op;
  uvh_pkg::uvh_pins_t  next_pins;
  uvh_pkg::uvh_resp_t  next_resp;
  logic [9:0]          cnt;
  logic [9:0]          next_cnt;
  logic [4:0]          npulse;
  logic [4:0]          next_npulse;
  logic [7:0]          rd;
  logic [10:0]         lowcnt;

  uvh_pin_sync u_sync (
    .clk (clk),
    .rst (rst),
    .d   (byte_data_lines),
    .q   (rd)
  );

  function automatic logic hit(input logic [9:0] c, input int lim);
    return c == 10'(lim - 1);
  endfunction

  assign req_ready  = (state == uvh_pkg::ST_IDLE);
  assign resp_valid = (state == uvh_pkg::ST_DONE);
  assign image_addr = pins.word_address;

  always_comb begin
    next_state  = state;
    next_op     = op;
    next_cnt    = cnt + 10'h001;
    next_npulse = npulse;
    next_resp   = resp;
    next_pins   = pins;
    unique case (state)
      uvh_pkg::ST_IDLE: begin
        next_cnt = 10'h000;
        if (req_valid) begin
          next_op = req.op;
          next_resp.pass = 1'b1;
          next_resp.fail_addr = `UVH_FIRST_ADDR;
          if (req.op == uvh_pkg::OP_PROGRAM) begin
            next_pins.word_address = `UVH_FIRST_ADDR;
            next_npulse = 5'h00;
            next_state = uvh_pkg::ST_PWR;
          end else if (req.op == uvh_pkg::OP_IDENT) begin
            next_pins.word_address = {15'h0000, req.addr[0]};
            next_state = uvh_pkg::ST_READ;
          end else begin
            next_pins.word_address = req.addr;
            next_state = uvh_pkg::ST_READ;
          end
        end
      end
      uvh_pkg::ST_PWR: begin
        if (hit(cnt, `UVH_SETTLE_CYC)) begin
          next_cnt = 10'h000;
          next_state = uvh_pkg::ST_SETUP;
        end
      end
      uvh_pkg::ST_SETUP: begin
        if (cnt == 10'h000) begin
          next_pins.byte_data_out = image_data;
        end
        // The byte gets one cycle to reach the pins before settling counts.
        if (hit(cnt, `UVH_SETTLE_CYC + 1)) begin
          next_cnt = 10'h000;
          next_npulse = npulse + 5'h01;
          next_state = uvh_pkg::ST_PULSE;
        end
      end
      uvh_pkg::ST_PULSE: begin
        if (hit(cnt, `UVH_PULSE_CYC)) begin
          next_cnt = 10'h000;
          next_state = uvh_pkg::ST_GAP;
        end
      end
      uvh_pkg::ST_GAP: begin
        if (hit(cnt, `UVH_SETTLE_CYC)) begin
          next_cnt = 10'h000;
          next_state = uvh_pkg::ST_VER;
        end
      end
      uvh_pkg::ST_VER: begin
        if (hit(cnt, `UVH_VER_CYC)) begin
          next_cnt = 10'h000;
          if (rd == pins.byte_data_out) begin
            next_npulse = 5'h00;
            if (pins.word_address == `UVH_LAST_ADDR) begin
              next_pins.word_address = `UVH_FIRST_ADDR;
              next_state = uvh_pkg::ST_FPWR;
            end else begin
              next_pins.word_address = pins.word_address + 16'h0001;
              next_state = uvh_pkg::ST_SETUP;
            end
          end else if (npulse == `UVH_MAX_PULSES) begin
            next_resp.pass = 1'b0;
            next_resp.fail_addr = pins.word_address;
            next_resp.rdata = rd;
            next_state = uvh_pkg::ST_DONE;
          end else begin
            next_state = uvh_pkg::ST_SETUP;
          end
        end
      end
      uvh_pkg::ST_FPWR: begin
        if (hit(cnt, `UVH_SETTLE_CYC)) begin
          next_cnt = 10'h000;
          next_state = uvh_pkg::ST_FREAD;
        end
      end
      uvh_pkg::ST_FREAD: begin
        // Select and gate stay low; only the address walks, like a burst.
        if (hit(cnt, `UVH_ACC_CYC)) begin
          next_cnt = 10'h000;
          next_resp.rdata = rd;
          if (rd != image_data) begin
            next_resp.pass = 1'b0;
            next_resp.fail_addr = pins.word_address;
            next_state = uvh_pkg::ST_DONE;
          end else if (pins.word_address == `UVH_LAST_ADDR) begin
            next_state = uvh_pkg::ST_DONE;
          end else begin
            next_pins.word_address = pins.word_address + 16'h0001;
          end
        end
      end
      uvh_pkg::ST_READ: begin
        if (hit(cnt, `UVH_ACC_CYC)) begin
          next_resp.rdata = rd;
          // Identifier bytes must show odd parity; a mismatch flags a
          // missing part or a bad high-voltage contact.
          next_resp.pass = (op == uvh_pkg::OP_IDENT) ? ^rd : 1'b1;
          next_state = uvh_pkg::ST_DONE;
        end
      end
      uvh_pkg::ST_DONE: begin
        next_cnt = 10'h000;
        next_state = uvh_pkg::ST_IDLE;
      end
    endcase
    // Pin levels follow the next state so that they come from flip-flops.
    next_pins.ce_n = !(next_state inside {uvh_pkg::ST_PULSE,
        uvh_pkg::ST_VER, uvh_pkg::ST_FREAD, uvh_pkg::ST_READ});
    next_pins.oe_n = !(next_state inside {uvh_pkg::ST_VER,
        uvh_pkg::ST_FREAD, uvh_pkg::ST_READ});
    next_pins.vpp_en = next_state inside {uvh_pkg::ST_SETUP,
        uvh_pkg::ST_PULSE};
    next_pins.byte_data_oe = next_pins.vpp_en;
    next_pins.vcc_prog = next_state inside {uvh_pkg::ST_PWR,
        uvh_pkg::ST_SETUP, uvh_pkg::ST_PULSE, uvh_pkg::ST_GAP,
        uvh_pkg::ST_VER};
    next_pins.identify_high_level = (next_state == uvh_pkg::ST_READ) &&
        (next_op == uvh_pkg::OP_IDENT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state  <= uvh_pkg::ST_IDLE;
      op     <= uvh_pkg::OP_READ;
      cnt    <= 10'h000;
      npulse <= 5'h00;
      resp   <= '{rdata: 8'hff, pass: 1'b0, fail_addr: 16'h0000};
      pins   <= '{word_address: 16'h0000, ce_n: 1'b1, oe_n: 1'b1,
                  vpp_en: 1'b0, vcc_prog: 1'b0, identify_high_level: 1'b0,
                  byte_data_out: 8'hff, byte_data_oe: 1'b0};
    end else begin
      state  <= next_state;
      op     <= next_op;
      cnt    <= next_cnt;
      npulse <= next_npulse;
      resp   <= next_resp;
      pins   <= next_pins;
    end
  end

  // Counts completed low cycles of the chip select; checks only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowcnt <= 11'h000;
    end else begin
      lowcnt <= pins.ce_n ? 11'h000 : lowcnt + 11'h001;
    end
  end

  vpp_needs_vcc_a: assert property (
    @(posedge clk) disable iff (rst)
    pins.vpp_en |-> pins.vcc_prog && $past(pins.vcc_prog))
    else $error("Programming level raised without elevated supply.");

  data_drive_a: assert property (
    @(posedge clk) disable iff (rst)
    pins.byte_data_oe |-> pins.oe_n && pins.vpp_en)
    else $error("Data lines driven while the memory may drive them.");

  pulse_width_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(pins.ce_n) && $past(pins.vpp_en) |->
      lowcnt == 11'(`UVH_PULSE_CYC))
    else $error("Program pulse length is wrong.");

  pulse_setup_a: assert property (
    @(posedge clk) disable iff (rst)
    $fell(pins.ce_n) && pins.vpp_en |->
      $past(pins.byte_data_oe, 2) && $stable(pins.word_address)
      && $stable(pins.byte_data_out))
    else $error("Program pulse started before lines settled.");

  pulse_limit_a: assert property (
    @(posedge clk) disable iff (rst)
    (state == uvh_pkg::ST_VER) && (next_state == uvh_pkg::ST_DONE) |->
      npulse == `UVH_MAX_PULSES ##1 resp_valid && !resp.pass)
    else $error("Gave up on a location at the wrong pulse count.");

  addr_walk_a: assert property (
    @(posedge clk) disable iff (rst)
    $changed(pins.word_address) && $past(pins.vcc_prog) |->
      pins.word_address == $past(pins.word_address) + 16'h0001
      || pins.word_address == `UVH_FIRST_ADDR)
    else $error("Programming skipped an address.");

  final_supply_a: assert property (
    @(posedge clk) disable iff (rst)
    state == uvh_pkg::ST_FREAD |-> !pins.vcc_prog && !pins.vpp_en
      && !pins.ce_n && !pins.oe_n)
    else $error("Final read back not at normal supply.");

  verify_time_a: assert property (
    @(posedge clk) disable iff (rst)
    (state == uvh_pkg::ST_VER) && hit(cnt, `UVH_VER_CYC) |->
      lowcnt == 11'(`UVH_VER_CYC - 1) && !pins.oe_n && !pins.vpp_en)
    else $error("Verify sampled too early or with gate high.");

  ident_addr_a: assert property (
    @(posedge clk) disable iff (rst)
    pins.identify_high_level |-> pins.word_address[15:1] == 15'h0000
      && !pins.vpp_en)
    else $error("Address lines not low during identify.");

  gate_with_select_a: assert property (
    @(posedge clk) disable iff (rst)
    !pins.oe_n |-> !pins.ce_n)
    else $error("Read strobe asserted with the device deselected.");

  vpp_gate_high_a: assert property (
    @(posedge clk) disable iff (rst)
    pins.vpp_en |-> pins.oe_n && !pins.identify_high_level)
    else $error("Programming qualifier with gate logically low.");

endmodule // uvh_ctrl

`default_nettype wire

// File: dv/uvh_mem_model.sv
/*
  Behavioural model of the 64K by 8 UV EPROM that the controller drives.
  Assumes the bench resolves the shared data wire and feeds it to dq.
*/
`timescale 1ns/1ps
`default_nettype none

module uvh_mem_model #(
  // Both identifier codes are arbitrary; they only need odd parity.
  parameter logic [7:0] MAKER_CODE = 8'h83,
  parameter logic [7:0] PART_CODE  = 8'h8c
) (
  input  wire uvh_pkg::uvh_pins_t pins,
  input  wire logic [7:0]         dq,
  input  wire logic               stuck,
  output var  logic [7:0]         q,
  output var  logic [7:0]         pulse_cnt,
  output var  logic [31:0]        pulse_ns,
  output var  logic               prog_bad
);
  logic [7:0]  arr [0:65535];
  logic [7:0]  last;
  logic [7:0]  pdata;
  logic [15:0] paddr;
  logic        parmed;
  realtime     t0;

  initial begin
    for (int i = 0; i < 65536; i++) arr[i] = 8'hff;
    last = 8'h00;
    pulse_cnt = 8'h00;
    pulse_ns = 32'h0;
    prog_bad = 1'b0;
    parmed = 1'b0;
  end

  // Address and data are latched at the falling edge, since the controller
  // drops the programming level in the same cycle as it ends the pulse.
  always @(negedge pins.ce_n) begin
    t0 = $realtime;
    parmed = pins.vpp_en;
    paddr = pins.word_address;
    pdata = dq;
    if (pins.vpp_en && !pins.vcc_prog) prog_bad = 1'b1;
  end

  always @(posedge pins.ce_n) begin
    if (parmed) begin
      pulse_ns = 32'($rtoi($realtime - t0));
      pulse_cnt = pulse_cnt + 8'h01;
      if (!stuck) arr[paddr] = arr[paddr] & pdata;
    end
    parmed = 1'b0;
  end

  // A released line shows the inverse of its last value, not a kept level.
  always @(pins, pulse_cnt) begin
    if (!pins.ce_n && !pins.oe_n && !pins.vpp_en) begin
      if (pins.identify_high_level) begin
        if (pins.word_address[15:1] == 15'h0) begin
          last = pins.word_address[0] ? PART_CODE : MAKER_CODE;
        end else begin
          last = 8'h00;
        end
      end else begin
        last = arr[pins.word_address];
      end
      q = last;
    end else begin
      q = ~last;
    end
  end
endmodule // uvh_mem_model

`default_nettype wire

// File: dv/tb_uv_eprom_mode_and_program_control.sv
/*
  Self-checking bench for the EPROM controller with a memory model.
  Assumes the controller of uvh_ctrl and the model of uvh_mem_model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_uv_eprom_mode_and_program_control;
  // Identifier values are arbitrary, chosen only to carry odd parity.
  localparam logic [7:0] MAKER = 8'h83;
  localparam logic [7:0] PART  = 8'h8c;

  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               req_valid = 1'b0;
  logic               stuck = 1'b0;
  uvh_pkg::uvh_req_t  req = '0;
  logic               req_ready;
  logic               resp_valid;
  uvh_pkg::uvh_resp_t resp;
  logic [15:0]        image_addr;
  logic [7:0]         image_data;
  uvh_pkg::uvh_pins_t pins;
  logic [7:0]         mq;
  logic [7:0]         pc;
  logic [31:0]        pns;
  logic               pbad;
  wire logic [7:0]    dq_w;
  int                 error_cnt = 0;
  int                 num_checks = 0;

  always #50 clk = ~clk;

  // The image must follow image_addr within the same cycle.
  assign image_data = image_addr[7:0] ^ 8'h5a;
  assign dq_w = pins.byte_data_oe ? pins.byte_data_out : mq;

  uvh_ctrl DUT (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .resp_valid(resp_valid), .resp(resp),
    .image_addr(image_addr), .image_data(image_data), .pins(pins),
    .byte_data_lines(dq_w)
  );

  uvh_mem_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) mem (
    .pins(pins), .dq(dq_w), .stuck(stuck), .q(mq), .pulse_cnt(pc),
    .pulse_ns(pns), .prog_bad(pbad)
  );

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic start(uvh_pkg::uvh_op_t op, logic [15:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a};
    @(negedge clk);
    chk("req_ready", 1, req_ready);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task automatic run(uvh_pkg::uvh_op_t op, logic [15:0] a, int lim,
                     output int lat);
    start(op, a);
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (resp_valid !== 1'b1 && lat < lim);
    chk("resp_valid", 1, resp_valid);
  endtask

  task automatic s_read_erased;
    int lat;
    run(uvh_pkg::OP_READ, 16'h1234, 20, lat);
    chk("read latency", 7, lat);
    chk("erased byte", 8'hff, resp.rdata);
    chk("read pass", 1, resp.pass);
    run(uvh_pkg::OP_READ, 16'hffff, 20, lat);
    chk("erased top byte", 8'hff, resp.rdata);
    @(negedge clk);
    chk("standby select", 1, pins.ce_n);
    chk("standby gate", 1, pins.oe_n);
  endtask

  task automatic s_ident;
    int lat;
    for (int i = 0; i < 2; i++) begin
      run(uvh_pkg::OP_IDENT, 16'(i), 20, lat);
      chk("id byte", (i == 1) ? PART : MAKER, resp.rdata);
      chk("id parity", 1, resp.pass);
    end
  endtask

  task automatic s_prog_stuck;
    int lat;
    stuck = 1'b1;
    run(uvh_pkg::OP_PROGRAM, 16'h0000, 30000, lat);
    chk("stuck pass", 0, resp.pass);
    chk("stuck fail_addr", 16'h0000, resp.fail_addr);
    chk("stuck rdata", 8'hff, resp.rdata);
    chk("pulse count", 25, pc);
    chk("pulse length ns", 100000, pns);
    chk("stuck cell", 8'hff, mem.arr[0]);
  endtask

  task automatic s_prog_abort;
    int n;
    int lat;
    stuck = 1'b0;
    start(uvh_pkg::OP_PROGRAM, 16'h0000);
    n = 0;
    while (image_addr !== 16'h0003 && n < 10000) begin
      @(negedge clk);
      n++;
    end
    chk("walk address", 16'h0003, image_addr);
    for (int i = 0; i < 3; i++)
      chk("programmed cell", 8'(i) ^ 8'h5a, mem.arr[i]);
    chk("pulse total", 28, pc);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk("reset select", 1, pins.ce_n);
    chk("reset vpp", 0, pins.vpp_en);
    chk("reset supply", 0, pins.vcc_prog);
    chk("reset data drive", 0, pins.byte_data_oe);
    @(posedge clk);
    rst <= 1'b0;
    run(uvh_pkg::OP_READ, 16'h0001, 20, lat);
    chk("read back", 8'h5b, resp.rdata);
    chk("supply order", 0, pbad);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    s_read_erased();
    s_ident();
    s_prog_stuck();
    s_prog_abort();
    conclude();
  end

  initial begin
    #6000000;
    error_cnt++;
    conclude();
  end
endmodule // tb_uv_eprom_mode_and_program_control

`default_nettype wire
